// File: rtl/cio_cfg.svh
// offsets, reset values and sizes for the configurable i/o ports
`ifndef CIO_CFG_SVH
`define CIO_CFG_SVH

// ==================================================
// sizes
`define CIO_NPORT      4
`define CIO_NWIDE      3
`define CIO_AW         8
`define CIO_DW         8
`define CIO_BUS_AW     16

// ==================================================
// register offsets inside one port block
`define CIO_PORT_STRIDE 3
`define CIO_OFF_DIN    3'h0
`define CIO_OFF_DOUT   3'h1
`define CIO_OFF_DIR    3'h2
`define CIO_OFF_CTL    3'h3
`define CIO_OFF_MC     3'h4
`define CIO_OFF_IMC    3'h5

// ==================================================
// pin masks
`define CIO_MASK_WIDE  8'hff
`define CIO_MASK_NARR  8'h07

// ==================================================
// reset values
`define CIO_DOUT_RST   8'h00
`define CIO_DIR_RST    8'h00
`define CIO_CTL_RST    8'h00
`define CIO_ADDR_RST   16'h0000

`endif

// File: rtl/cio_pkg.sv
// types shared by the configurable i/o ports
package cio_pkg;

  // ==================================================
  // output mux source, one-hot
  typedef enum logic [3:0] {
    SRC_DOUT = 4'b0001,
    SRC_ADDR = 4'b0010,
    SRC_MC   = 4'b0100,
    SRC_CS   = 4'b1000
  } cio_src_t;

  // ==================================================
  // nonvolatile configuration of one port
  typedef struct packed {
    logic [7:0] mc_out;
    logic [7:0] cs_out;
    logic [7:0] pt_def;
    logic [7:0] pld_in;
    logic [7:0] imc_latch;
    logic [7:0] imc_reg;
    logic [1:0] imc_pt_clk;
    logic       addr_hi;
  } cio_nv_t;

  // ==================================================
  // logic-array signals of one port
  typedef struct packed {
    logic [7:0] mc;
    logic [7:0] pt_oe;
    logic [7:0] cs;
  } cio_pld_t;

endpackage

// File: rtl/cio_ports.sv
// configurable i/o ports: registers, output mux, drivers, input macrocells
// Summary of operation
// - four ports; three eight pins wide, the fourth three pins wide.
// - each pin set by nonvolatile configuration or mcu register writes.
// - output mux picks data out, latched address, macrocell or chip select.
// - read buffer puts at most one source on the data bus per read.
// - read sources: data out, macrocells, direction, control, pin level.
// - driver enable is product term OR direction bit.
// - without defined product term or macrocell output, direction bit rules.
// - configuration and data registers writable and readable back.
// - wide ports have input macrocells: latch, edge register or pass.
// - macrocells clocked by address strobe or product term; readable.
// - logic-array modes fixed by configuration; others changed at run time.
// - writing zero to a control bit puts the pin in mcu i/o mode.
// - mcu i/o direction follows direction bit or product term.
// - mcu i/o output driven from data out; input read via data in.
// - third and fourth ports lack control, default to mcu i/o.
// - logic-array pin is macrocell input, output, or both.
// - logic-array output floats per product term or direction bit zero.
// - an assigned pin is not reused for another function.
// - registers reached by plain read and write cycles at fixed offsets.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "cio_cfg.svh"

module cio_ports (
  input  wire logic                           MCLK_I,
  input  wire logic                           RESET_I,
  input  wire logic                           CE_I,
  input  wire logic [`CIO_AW-1:0]             ADDR_I,
  input  wire logic [`CIO_DW-1:0]             WDATA_I,
  input  wire logic                           WR_I,
  input  wire logic                           RD_I,
  output logic      [`CIO_DW-1:0]             RDATA_O,
  input  wire logic                           ADDR_LATCH_STROBE_I,
  input  wire logic [`CIO_BUS_AW-1:0]         BUS_ADDR_I,
  input  wire cio_pkg::cio_nv_t  [`CIO_NPORT-1:0] NV_CFG_I,
  input  wire cio_pkg::cio_pld_t [`CIO_NPORT-1:0] PLD_I,
  input  wire logic [`CIO_NWIDE-1:0][1:0]     IMC_PT_I,
  input  wire logic [`CIO_NPORT-1:0][7:0]     PIN_I,
  output logic      [`CIO_NPORT-1:0][7:0]     PIN_O,
  output logic      [`CIO_NPORT-1:0][7:0]     PIN_OE_N_O,
  output logic      [`CIO_NWIDE-1:0][7:0]     IMC_BUS_O
);

  // ==================================================
  // helpers
  function automatic logic [7:0] pin_mask(input int p);
    pin_mask = (p == `CIO_NPORT - 1) ? `CIO_MASK_NARR : `CIO_MASK_WIDE;
  endfunction

  function automatic cio_pkg::cio_src_t src_sel(input logic mc,
                                                input logic cs,
                                                input logic ctl);
    if (mc)       src_sel = cio_pkg::SRC_MC;
    else if (cs)  src_sel = cio_pkg::SRC_CS;
    else if (ctl) src_sel = cio_pkg::SRC_ADDR;
    else          src_sel = cio_pkg::SRC_DOUT;
  endfunction

  function automatic logic imc_en(input logic sel,
                                  input logic pt,
                                  input logic strobe);
    imc_en = sel ? pt : strobe;
  endfunction

  function automatic logic reg_hit(input logic [`CIO_AW-1:0] a,
                                   input int                 p,
                                   input logic [2:0]         off);
    reg_hit = (a == {p[`CIO_AW-4:0], off});
  endfunction

  // ==================================================
  // state
  logic [`CIO_NPORT-1:0][7:0] dout_ff;
  logic [`CIO_NPORT-1:0][7:0] dir_ff;
  logic [1:0][7:0]            ctl_ff;
  logic [`CIO_NPORT-1:0][7:0] sync1_ff;
  logic [`CIO_NPORT-1:0][7:0] sync2_ff;
  logic [`CIO_BUS_AW-1:0]     addr_lat_ff;
  logic [`CIO_NWIDE-1:0][7:0] imc_ff;
  logic [`CIO_NWIDE-1:0][1:0] en_prev_ff;
  logic [`CIO_NPORT-1:0][7:0] pin_o_ff;
  logic [`CIO_NPORT-1:0][7:0] pin_oe_n_ff;
  logic [`CIO_DW-1:0]         rdata_ff;

  logic [`CIO_NPORT-1:0][7:0] nxt_pin_o;
  logic [`CIO_NPORT-1:0][7:0] nxt_pin_oe_n;
  logic [`CIO_NWIDE-1:0][7:0] nxt_imc;
  logic [`CIO_DW-1:0]         nxt_rdata;

  // ==================================================
  // pin synchronisers
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (CE_I) begin
      sync1_ff <= PIN_I;
      sync2_ff <= sync1_ff;
    end
  end

  // ==================================================
  // register writes
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int p = 0; p < `CIO_NPORT; p++) begin
        dout_ff[p] <= `CIO_DOUT_RST;
        dir_ff[p]  <= `CIO_DIR_RST;
      end
      for (int p = 0; p < 2; p++) begin
        ctl_ff[p] <= `CIO_CTL_RST;
      end
    end else if (CE_I && WR_I) begin
      for (int p = 0; p < `CIO_NPORT; p++) begin
        if (reg_hit(ADDR_I, p, `CIO_OFF_DOUT)) begin
          dout_ff[p] <= WDATA_I & pin_mask(p);
        end
        if (reg_hit(ADDR_I, p, `CIO_OFF_DIR)) begin
          dir_ff[p] <= WDATA_I & pin_mask(p);
        end
      end
      for (int p = 0; p < 2; p++) begin
        if (reg_hit(ADDR_I, p, `CIO_OFF_CTL)) begin
          ctl_ff[p] <= WDATA_I;
        end
      end
    end
  end

  // ==================================================
  // address latch
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      addr_lat_ff <= `CIO_ADDR_RST;
    end else if (CE_I && ADDR_LATCH_STROBE_I) begin
      addr_lat_ff <= BUS_ADDR_I;
    end
  end

  // ==================================================
  // output mux and pin masking
  always_comb begin
    logic              ctl;
    logic              lat;
    logic [7:0]        msk;
    cio_pkg::cio_src_t src;
    ctl = 1'b0;
    lat = 1'b0;
    msk = 8'h00;
    src = cio_pkg::SRC_DOUT;
    for (int p = 0; p < `CIO_NPORT; p++) begin
      msk = pin_mask(p);
      for (int i = 0; i < 8; i++) begin
        // logic-array assignment overrides run-time control bits
        ctl = (p < 2) ? (ctl_ff[p[0]][i] & ~NV_CFG_I[p].mc_out[i]
                         & ~NV_CFG_I[p].cs_out[i]) : 1'b0;
        lat = (p == 1 && NV_CFG_I[p].addr_hi) ? addr_lat_ff[8+i]
                                               : addr_lat_ff[i];
        src = src_sel(NV_CFG_I[p].mc_out[i], NV_CFG_I[p].cs_out[i], ctl);
        unique case (src)
          cio_pkg::SRC_MC:   nxt_pin_o[p][i] = PLD_I[p].mc[i];
          cio_pkg::SRC_CS:   nxt_pin_o[p][i] = PLD_I[p].cs[i];
          cio_pkg::SRC_ADDR: nxt_pin_o[p][i] = lat;
          cio_pkg::SRC_DOUT: nxt_pin_o[p][i] = dout_ff[p][i];
        endcase
        nxt_pin_o[p][i] = nxt_pin_o[p][i] & msk[i];
      end
    end
  end

  // ==================================================
  // driver enable
  always_comb begin
    logic       pt;
    logic [7:0] msk;
    pt  = 1'b0;
    msk = 8'h00;
    for (int p = 0; p < `CIO_NPORT; p++) begin
      msk = pin_mask(p);
      for (int i = 0; i < 8; i++) begin
        // product term counts only where one is defined
        pt = NV_CFG_I[p].pt_def[i] & PLD_I[p].pt_oe[i];
        // active-low enable: driven when product term or direction set
        nxt_pin_oe_n[p][i] = ~((pt | dir_ff[p][i]) & msk[i]);
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pin_o_ff    <= '0;
      pin_oe_n_ff <= '1;
    end else if (CE_I) begin
      pin_o_ff    <= nxt_pin_o;
      pin_oe_n_ff <= nxt_pin_oe_n;
    end
  end

  // ==================================================
  // input macrocells
  always_comb begin
    logic en;
    en = 1'b0;
    for (int p = 0; p < `CIO_NWIDE; p++) begin
      for (int i = 0; i < 8; i++) begin
        en = imc_en(NV_CFG_I[p].imc_pt_clk[i/4], IMC_PT_I[p][i/4],
                    ADDR_LATCH_STROBE_I);
        if (NV_CFG_I[p].imc_latch[i]) begin
          nxt_imc[p][i] = en ? sync2_ff[p][i] : imc_ff[p][i];
        end else if (NV_CFG_I[p].imc_reg[i]) begin
          nxt_imc[p][i] = (en && !en_prev_ff[p][i/4]) ? sync2_ff[p][i]
                                                       : imc_ff[p][i];
        end else begin
          nxt_imc[p][i] = sync2_ff[p][i];
        end
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      imc_ff     <= '0;
      en_prev_ff <= '0;
    end else if (CE_I) begin
      imc_ff <= nxt_imc;
      for (int p = 0; p < `CIO_NWIDE; p++) begin
        for (int n = 0; n < 2; n++) begin
          en_prev_ff[p][n] <= imc_en(NV_CFG_I[p].imc_pt_clk[n],
                                     IMC_PT_I[p][n], ADDR_LATCH_STROBE_I);
        end
      end
    end
  end

  // ==================================================
  // read buffer
  always_comb begin
    nxt_rdata = '0;
    if (RD_I) begin
      for (int p = 0; p < `CIO_NPORT; p++) begin
        unique case (1'b1)
          reg_hit(ADDR_I, p, `CIO_OFF_DIN):
            nxt_rdata = sync2_ff[p] & pin_mask(p);
          reg_hit(ADDR_I, p, `CIO_OFF_DOUT):
            nxt_rdata = dout_ff[p];
          reg_hit(ADDR_I, p, `CIO_OFF_DIR):
            nxt_rdata = dir_ff[p];
          reg_hit(ADDR_I, p, `CIO_OFF_CTL):
            nxt_rdata = (p < 2) ? ctl_ff[p[0]] : 8'h00;
          reg_hit(ADDR_I, p, `CIO_OFF_MC):
            nxt_rdata = PLD_I[p].mc & pin_mask(p);
          reg_hit(ADDR_I, p, `CIO_OFF_IMC):
            nxt_rdata = (p < `CIO_NWIDE) ? imc_ff[p[1:0]] : 8'h00;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rdata_ff <= '0;
    end else if (CE_I) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA_O    = rdata_ff;
  assign PIN_O      = pin_o_ff;
  assign PIN_OE_N_O = pin_oe_n_ff;
  assign IMC_BUS_O  = imc_ff;

endmodule

// File: tb/cio_pin_model.sv
// pin-side model: outside drivers meet the block's pin outputs
`timescale 1ns/1ps
module cio_pin_model (
  input  wire logic [3:0][7:0] drv_i,
  input  wire logic [3:0][7:0] oe_n_i,
  input  wire logic [7:0]      ext_i,
  output logic      [3:0][7:0] pin_o
);
  // ====
  // released pins take the outside pattern, never the last drive
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_o[p] = (drv_i[p] & ~oe_n_i[p]) | (ext_i & oe_n_i[p]);
    end
  end
endmodule

// File: tb/cio_ports_assertions.sv
// concurrent checks on the configurable i/o ports
`timescale 1ns/1ps
module cio_ports_assertions (
  input wire logic                    MCLK_I,
  input wire logic                    RESET_I,
  input wire logic                    CE_I,
  input wire logic [7:0]              ADDR_I,
  input wire logic [7:0]              WDATA_I,
  input wire logic                    WR_I,
  input wire logic                    RD_I,
  input wire logic [7:0]              RDATA_O,
  input wire cio_pkg::cio_nv_t  [3:0] NV_CFG_I,
  input wire cio_pkg::cio_pld_t [3:0] PLD_I,
  input wire logic [3:0][7:0]         PIN_O,
  input wire logic [3:0][7:0]         PIN_OE_N_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // ====
  // checks
  a_read_idle_zero: assert property (CE_I && !RD_I |=> RDATA_O == 8'h00)
    else $error("read data not zero");
  a_freeze_state: assert property (!CE_I |=> $stable(PIN_O) && $stable(RDATA_O))
    else $error("state moved while frozen");
  a_narrow_oe_off: assert property (PIN_OE_N_O[3][7:3] == 5'h1f)
    else $error("narrow port upper enable");
  a_narrow_out_zero: assert property (PIN_O[3][7:3] == 5'h00)
    else $error("narrow port upper drive");
  a_dir_sets_oe: assert property ((WR_I && CE_I && ADDR_I == 8'h02) ##1
    (CE_I && NV_CFG_I[0].pt_def == 8'h00) |=> PIN_OE_N_O[0] == ~$past(WDATA_I, 2))
    else $error("enable not from direction");
  a_term_enables: assert property (CE_I |=> (PIN_OE_N_O[1] &
    $past(NV_CFG_I[1].pt_def & PLD_I[1].pt_oe)) == 8'h00)
    else $error("product term enable lost");
  a_dout_to_pin: assert property ((WR_I && CE_I && ADDR_I == 8'h11) ##1
    (CE_I && (NV_CFG_I[2].mc_out | NV_CFG_I[2].cs_out) == 8'h00)
    |=> PIN_O[2] == $past(WDATA_I, 2))
    else $error("data out not on pins");
  a_mc_to_pin: assert property (CE_I && NV_CFG_I[1].mc_out == 8'hff
    |=> PIN_O[1] == $past(PLD_I[1].mc))
    else $error("macrocell not on pins");
  a_cs_to_pin: assert property (CE_I && NV_CFG_I[0].mc_out == 8'h00 &&
    NV_CFG_I[0].cs_out == 8'hff |=> PIN_O[0] == $past(PLD_I[0].cs))
    else $error("chip select not on pins");
endmodule
bind cio_ports cio_ports_assertions cio_ports_assertions_i (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .NV_CFG_I(NV_CFG_I), .PLD_I(PLD_I), .PIN_O(PIN_O),
  .PIN_OE_N_O(PIN_OE_N_O));

// File: tb/cio_ports_test.sv
// self-checking bench for the configurable i/o ports
`timescale 1ns/1ps
module cio_ports_test;
  logic                    mclk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  logic                    wr = 1'b0;
  logic                    rd = 1'b0;
  logic                    als = 1'b0;
  logic [7:0]              addr = 8'h00;
  logic [7:0]              wdata = 8'h00;
  logic [7:0]              ext = 8'hc3;
  logic [7:0]              rdata;
  logic [15:0]             bus_addr = 16'h1234;
  cio_pkg::cio_nv_t  [3:0] nv = '0;
  cio_pkg::cio_pld_t [3:0] pld = '0;
  logic [2:0][1:0]         imc_pt = '0;
  logic [3:0][7:0]         pin;
  logic [3:0][7:0]         pout;
  logic [3:0][7:0]         oe_n;
  logic [2:0][7:0]         input_macrocell;
  int                      err_total = 0;
  int                      n_compared = 0;
  always #25 mclk = ~mclk;
  cio_ports cio_ports_i (.MCLK_I(mclk), .RESET_I(rst), .CE_I(ce),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .ADDR_LATCH_STROBE_I(als), .BUS_ADDR_I(bus_addr), .NV_CFG_I(nv),
    .PLD_I(pld), .IMC_PT_I(imc_pt), .PIN_I(pin), .PIN_O(pout),
    .PIN_OE_N_O(oe_n), .IMC_BUS_O(input_macrocell));
  cio_pin_model cio_pin_model_i (.drv_i(pout), .oe_n_i(oe_n), .ext_i(ext),
    .pin_o(pin));
  // ====
  // tasks
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk("read data", exp, rdata);
  endtask
  task automatic settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
  // ====
  // sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("enable a", 8'hff, oe_n[0]);
    for (int p = 0; p < 4; p++) begin
      rd_reg(8'(p * 8 + 2), 8'h00);
      wr_reg(8'(p * 8 + 1), 8'ha5);
      wr_reg(8'(p * 8 + 2), 8'h3c);
      wr_reg(8'(p * 8 + 3), 8'h5a);
      rd_reg(8'(p * 8 + 1), p == 3 ? 8'h05 : 8'ha5);
      rd_reg(8'(p * 8 + 3), p < 2 ? 8'h5a : 8'h00);
    end
    wr_reg(8'h27, 8'hff);
    rd_reg(8'h27, 8'h00);
    rd_reg(8'h06, 8'h00);
    @(posedge mclk);
    als <= 1'b1;
    @(posedge mclk);
    als <= 1'b0;
    settle();
    chk("enable a", 8'hc3, oe_n[0]);
    chk("enable d", 8'hfb, oe_n[3]);
    chk("pins c", 8'ha5, pout[2]);
    chk("pins a", 8'hb5, pout[0]);
    chk("pins b", 8'hb5, pout[1]);
    wr_reg(8'h03, 8'h00);
    settle();
    chk("pins a", 8'ha5, pout[0]);
    rd_reg(8'h10, 8'he7);
    rd_reg(8'h18, 8'h07);
    chk("imc c", 8'he7, input_macrocell[2]);
    rd_reg(8'h15, 8'he7);
    @(posedge mclk);
    als <= 1'b1;
    nv[2].imc_latch <= 8'hff;
    settle();
    @(posedge mclk);
    als <= 1'b0;
    settle();
    @(posedge mclk);
    ext <= 8'h00;
    settle();
    chk("imc c", 8'he7, input_macrocell[2]);
    @(posedge mclk);
    als <= 1'b1;
    settle();
    chk("imc c", 8'h24, input_macrocell[2]);
    @(posedge mclk);
    nv[1].mc_out <= 8'hff;
    nv[1].pt_def <= 8'hff;
    pld[1].mc <= 8'h96;
    pld[1].pt_oe <= 8'h0f;
    settle();
    chk("pins b", 8'h96, pout[1]);
    chk("enable b", 8'hc0, oe_n[1]);
    rd_reg(8'h0c, 8'h96);
    wr_reg(8'h0a, 8'h00);
    settle();
    chk("enable b", 8'hf0, oe_n[1]);
    @(posedge mclk);
    nv[0].cs_out <= 8'hff;
    pld[0].cs <= 8'h69;
    settle();
    chk("pins a", 8'h69, pout[0]);
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(8'h11, 8'h00);
    ce <= 1'b1;
    settle();
    chk("pins c", 8'ha5, pout[2]);
    report_and_stop();
  end
endmodule
